// >>> inc/vic_pkg.sv
// shared constants for the fast interrupt, forcing and protect logic
`default_nettype none
package vic_pkg;
    // default source count and priority stack depth
    localparam int NSRC_DEF = 32;
    localparam int DEPTH_DEF = 8;
    // vector width and vector reset value
    localparam int VEC_W = 32;
    localparam logic [VEC_W-1:0] VEC_RESET = 32'h0000_0000;
    // source mode layout: priority field low, source type above it
    localparam int SMR_W = 7;
    localparam int PRIO_W = 3;
    localparam int SMR_PRIO_LSB = 0;
    localparam int TYPE_W = 2;
    localparam int SMR_TYPE_LSB = 5;
    localparam logic [SMR_W-1:0] SMR_RESET = 7'h00;
    // source type bits: bit 0 selects edge, bit 1 forces active-high
    localparam int TYPE_EDGE_BIT = 0;
    localparam int TYPE_HIGH_BIT = 1;
    // the fast source index
    localparam int FAST_SRC = 0;
endpackage : vic_pkg
`default_nettype wire

// >>> rtl/vic_fast_ctrl.sv
// fast interrupt path, fast forcing, protect mode, spurious vector and general mask
`default_nettype none
module vic_fast_ctrl #(
    parameter int NSRC = vic_pkg::NSRC_DEF,
    parameter int DEPTH = vic_pkg::DEPTH_DEF,
    parameter int IW = $clog2(NSRC),
    parameter int SPW = $clog2(DEPTH + 1)
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [NSRC-1:0] i_src,
    input wire logic [NSRC-1:0] i_src_external,
    input wire logic [NSRC-1:0][vic_pkg::TYPE_W-1:0] i_src_type,
    input wire logic [NSRC-1:0][vic_pkg::PRIO_W-1:0] i_src_prio,
    input wire logic [NSRC-1:0] i_src_enable,
    input wire logic i_smr0_wr,
    input wire logic [vic_pkg::SMR_W-1:0] i_smr0_data,
    input wire logic i_svr_wr,
    input wire logic [IW-1:0] i_svr_idx,
    input wire logic [vic_pkg::VEC_W-1:0] i_svr_data,
    input wire logic [vic_pkg::VEC_W-1:0] i_spurious_vector,
    input wire logic i_protect_mode_bit,
    input wire logic i_global_mask_bit,
    input wire logic i_fvr_rd,
    input wire logic i_ivr_rd,
    input wire logic i_ivr_wr,
    input wire logic i_eoi_wr,
    input wire logic i_ffer_wr,
    input wire logic i_ffdr_wr,
    input wire logic i_clear_cmd_wr,
    input wire logic [NSRC-1:0] i_cmd_data,
    output logic o_fast_request_line_n,
    output logic o_normal_request_line_n,
    output logic o_wake,
    output logic [vic_pkg::VEC_W-1:0] o_rd_data,
    output logic [IW-1:0] o_current_source_status,
    output logic [NSRC-1:0] o_pending_status,
    output logic [NSRC-1:0] o_forcing_status,
    output logic [vic_pkg::SMR_W-1:0] o_source_zero_mode
);

    // refuse shapes the index and stack logic cannot serve
    if (NSRC < 2 || NSRC > 32 || DEPTH < 1 || IW != $clog2(NSRC) || SPW != $clog2(DEPTH + 1)) begin : g_bad
        $error("vic_fast_ctrl: unsupported NSRC or DEPTH");
    end

    typedef struct packed {
        logic [NSRC-1:0] sync1;
        logic [NSRC-1:0] sync2;
        logic [NSRC-1:0] act_prev;
        logic [NSRC-1:0] pend_edge;
        logic [NSRC-1:0] pend_q;
        logic [NSRC-1:0] ffsr;
        logic [vic_pkg::SMR_W-1:0] smr0;
        logic [NSRC-1:0][vic_pkg::VEC_W-1:0] svr;
        logic [DEPTH-1:0][vic_pkg::PRIO_W-1:0] stk_lvl;
        logic [DEPTH-1:0][IW-1:0] stk_idx;
        logic [SPW-1:0] sp;
        logic mem_valid;
        logic [IW-1:0] mem_idx;
        logic [vic_pkg::VEC_W-1:0] rd_data;
        logic fiq_n;
        logic irq_n;
        logic wake;
    } vic_state_t;

    vic_state_t st;
    vic_state_t next_st;

    // active polarity: external low/negative unless the high bit is set
    function automatic logic vic_active_high(input logic [vic_pkg::TYPE_W-1:0] typ, input logic ext);
        vic_active_high = typ[vic_pkg::TYPE_HIGH_BIT] | ~ext;
    endfunction

    // source type per source; source zero takes it from its own mode word
    logic [NSRC-1:0][vic_pkg::TYPE_W-1:0] typ;
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] is_edge;
    logic [NSRC-1:0] edge_hit;
    logic [NSRC-1:0] pend_all;
    logic [NSRC-1:0] cand;
    logic [NSRC-1:0] forced;
    logic forcing_in_use;
    logic best_found;
    logic [IW-1:0] best_idx;
    logic [vic_pkg::PRIO_W-1:0] best_prio;
    logic [vic_pkg::PRIO_W-1:0] cur_lvl;
    logic higher;
    logic fast_req;
    logic do_push;
    logic [IW-1:0] push_idx;
    logic [vic_pkg::PRIO_W-1:0] push_lvl;
    logic do_pop;

    // sensitivity decode and level or edge detection
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            typ[i] = i_src_type[i];
        end
        typ[vic_pkg::FAST_SRC] = st.smr0[vic_pkg::SMR_TYPE_LSB +: vic_pkg::TYPE_W];
        for (int i = 0; i < NSRC; i++) begin
            act[i] = vic_active_high(typ[i], i_src_external[i]) ? st.sync2[i] : ~st.sync2[i];
            is_edge[i] = typ[i][vic_pkg::TYPE_EDGE_BIT];
        end
        edge_hit = act & ~st.act_prev & is_edge;
        pend_all = (st.pend_edge & is_edge) | (act & ~is_edge);
    end

    // forcing masks and the fast request term
    always_comb begin
        forced = st.ffsr;
        forced[vic_pkg::FAST_SRC] = 1'b0;
        forcing_in_use = |forced;
        fast_req = (i_src_enable[vic_pkg::FAST_SRC] & pend_all[vic_pkg::FAST_SRC])
            | (|(i_src_enable & pend_all & forced));
        cand = i_src_enable & pend_all & ~forced;
        cand[vic_pkg::FAST_SRC] = 1'b0;
    end

    // arbitration: highest priority wins, ties go to the lowest index
    always_comb begin
        best_found = 1'b0;
        best_idx = '0;
        best_prio = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (cand[i] && (!best_found || i_src_prio[i] > best_prio)) begin
                best_found = 1'b1;
                best_idx = IW'(i);
                best_prio = i_src_prio[i];
            end
        end
        cur_lvl = (st.sp != '0) ? st.stk_lvl[st.sp - SPW'(1)] : '0;
        higher = best_found && ((st.sp == '0) || (best_prio > cur_lvl));
    end

    // push and acknowledge: on read in normal mode, on write in protect mode
    always_comb begin
        do_push = 1'b0;
        push_idx = best_idx;
        if (!i_protect_mode_bit) begin
            do_push = i_ivr_rd && higher;
        end else if (i_ivr_wr && st.mem_valid) begin
            do_push = 1'b1;
            push_idx = st.mem_idx;
        end
        if (st.sp == SPW'(DEPTH)) begin
            do_push = 1'b0;
        end
        push_lvl = i_src_prio[push_idx];
        do_pop = i_eoi_wr && !do_push && (st.sp != '0);
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.sync1 = i_src;
        next_st.sync2 = st.sync1;
        next_st.act_prev = act;
        // clear commands; a detected edge in the same cycle wins
        if (i_clear_cmd_wr) begin
            next_st.pend_edge = st.pend_edge & ~i_cmd_data;
        end
        if (i_fvr_rd && is_edge[vic_pkg::FAST_SRC] && !forcing_in_use) begin
            next_st.pend_edge[vic_pkg::FAST_SRC] = 1'b0;
        end
        if (do_push && is_edge[push_idx] && !forced[push_idx]) begin
            next_st.pend_edge[push_idx] = 1'b0;
        end
        next_st.pend_edge = next_st.pend_edge | edge_hit;
        next_st.pend_q = pend_all;
        // forcing status: set wins over disable
        if (i_ffdr_wr) begin
            next_st.ffsr = next_st.ffsr & ~i_cmd_data;
        end
        if (i_ffer_wr) begin
            next_st.ffsr = next_st.ffsr | i_cmd_data;
        end
        next_st.ffsr[vic_pkg::FAST_SRC] = 1'b0;
        if (i_smr0_wr) begin
            next_st.smr0 = i_smr0_data;
        end
        if (i_svr_wr) begin
            next_st.svr[i_svr_idx] = i_svr_data;
        end
        // read data: fast vector, active vector or spurious vector
        if (i_fvr_rd) begin
            next_st.rd_data = st.svr[vic_pkg::FAST_SRC];
        end else if (i_ivr_rd) begin
            next_st.rd_data = higher ? st.svr[best_idx] : i_spurious_vector;
            next_st.mem_valid = higher;
            next_st.mem_idx = best_idx;
        end
        // stack
        if (do_push) begin
            next_st.stk_lvl[st.sp] = push_lvl;
            next_st.stk_idx[st.sp] = push_idx;
            next_st.sp = st.sp + SPW'(1);
            if (i_protect_mode_bit) begin
                next_st.mem_valid = 1'b0;
            end
        end else if (do_pop) begin
            next_st.sp = st.sp - SPW'(1);
        end
        // request lines, masked; wake-up ignores the mask
        next_st.fiq_n = ~(fast_req & ~i_global_mask_bit);
        next_st.irq_n = ~(higher & ~i_global_mask_bit);
        next_st.wake = |(i_src_enable & pend_all);
    end

    // one register for the whole state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
            st.fiq_n <= 1'b1;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_fast_request_line_n = st.fiq_n;
    assign o_normal_request_line_n = st.irq_n;
    assign o_wake = st.wake;
    assign o_rd_data = st.rd_data;
    assign o_current_source_status = (st.sp != '0) ? st.stk_idx[st.sp - SPW'(1)] : '0;
    assign o_pending_status = st.pend_q;
    assign o_forcing_status = st.ffsr;
    assign o_source_zero_mode = st.smr0;

    // the mask keeps both lines high
    property p_gmask;
        @(posedge i_mclk) disable iff (i_rst)
        i_global_mask_bit |=> (o_fast_request_line_n && o_normal_request_line_n);
    endproperty
    a_gmask: assert property (p_gmask) else $error("request line active under mask");

    // wake-up follows pending enabled sources regardless of the mask
    property p_wake;
        @(posedge i_mclk) disable iff (i_rst)
        (i_global_mask_bit && |(i_src_enable & pend_all)) |=> o_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up blocked by mask");

    // fast line follows its source term
    property p_fast;
        @(posedge i_mclk) disable iff (i_rst)
        (fast_req && !i_global_mask_bit) |=> !o_fast_request_line_n;
    endproperty
    a_fast: assert property (p_fast) else $error("fast line not asserted");

    // fast vector read returns source zero vector
    property p_fvr;
        @(posedge i_mclk) disable iff (i_rst)
        i_fvr_rd |=> (o_rd_data == $past(st.svr[vic_pkg::FAST_SRC]));
    endproperty
    a_fvr: assert property (p_fvr) else $error("fast vector mismatch");

    // spurious read returns the spurious vector and pushes nothing
    property p_spur;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ivr_rd && !i_fvr_rd && !higher && !i_eoi_wr && !i_protect_mode_bit)
            |=> (o_rd_data == $past(i_spurious_vector)) && (st.sp == $past(st.sp));
    endproperty
    a_spur: assert property (p_spur) else $error("spurious read wrong");

    // normal mode read of a higher source pushes one level
    property p_push;
        @(posedge i_mclk) disable iff (i_rst)
        (!i_protect_mode_bit && i_ivr_rd && higher && st.sp != SPW'(DEPTH))
            |=> (st.sp == $past(st.sp) + SPW'(1)) && (o_current_source_status == $past(best_idx));
    endproperty
    a_push: assert property (p_push) else $error("normal read did not push");

    // protect mode reads alone leave the context as it was
    property p_protect;
        @(posedge i_mclk) disable iff (i_rst)
        (i_protect_mode_bit && !i_ivr_wr && !i_eoi_wr) |=> $stable(st.sp) && $stable(o_current_source_status);
    endproperty
    a_protect: assert property (p_protect) else $error("protect read changed context");

    // end of interrupt pops one level
    property p_pop;
        @(posedge i_mclk) disable iff (i_rst)
        (i_eoi_wr && !do_push && st.sp != '0) |=> (st.sp == $past(st.sp) - SPW'(1));
    endproperty
    a_pop: assert property (p_pop) else $error("end of interrupt did not pop");

    // forcing enable sets status bits two cycles on too
    property p_ffer;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ffer_wr && !i_ffdr_wr ##1 !i_ffdr_wr)
            |=> ((o_forcing_status & $past(i_cmd_data, 2)) == ($past(i_cmd_data, 2) & ~NSRC'(1)));
    endproperty
    a_ffer: assert property (p_ffer) else $error("forcing status not set");

    // fast vector read clears an edge source zero when nothing is forced
    property p_fvr_clr;
        @(posedge i_mclk) disable iff (i_rst)
        (i_fvr_rd && is_edge[vic_pkg::FAST_SRC] && !forcing_in_use && !edge_hit[vic_pkg::FAST_SRC])
            |=> !st.pend_edge[vic_pkg::FAST_SRC];
    endproperty
    a_fvr_clr: assert property (p_fvr_clr) else $error("fast read left source zero pending");

    // with forcing in use a fast vector read keeps source zero pending
    property p_fvr_keep;
        @(posedge i_mclk) disable iff (i_rst)
        (i_fvr_rd && forcing_in_use && st.pend_edge[vic_pkg::FAST_SRC] && !i_clear_cmd_wr)
            |=> st.pend_edge[vic_pkg::FAST_SRC];
    endproperty
    a_fvr_keep: assert property (p_fvr_keep) else $error("fast read cleared source zero under forcing");

    // a normal vector read leaves forced edge sources pending
    property p_ivr_forced;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ivr_rd && !i_clear_cmd_wr)
            |=> ((st.pend_edge & $past(forced & st.pend_edge)) == $past(forced & st.pend_edge));
    endproperty
    a_ivr_forced: assert property (p_ivr_forced) else $error("vector read cleared a forced source");

    // request lines and wake-up idle while reset is applied
    property p_rst_idle;
        @(posedge i_mclk)
        i_rst |=> (o_fast_request_line_n && o_normal_request_line_n && !o_wake);
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");

endmodule : vic_fast_ctrl
`default_nettype wire

// >>> verif/vic_core_model.sv
// core model that answers the fast request line by reading the fast vector
`default_nettype none
module vic_core_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_auto,
    input wire logic i_fast_request_line_n,
    output var logic o_fvr_rd = 1'b0,
    output var int o_reads = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt = 0;
    // one fast vector read per request, then a pause so the line can settle
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_fvr_rd <= 1'b0;
            wait_cnt <= 0;
            o_reads <= 0;
        end else if (o_fvr_rd) begin
            o_fvr_rd <= 1'b0;
            wait_cnt <= 4;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (i_auto && i_fast_request_line_n === 1'b0) begin
            o_fvr_rd <= 1'b1;
            o_reads <= o_reads + 1;
        end
    end
endmodule // vic_core_model
`default_nettype wire

// >>> verif/vic_fast_ctrl_tb_top.sv
// self-checking bench for the fast interrupt, forcing and protect logic
`default_nettype none
module vic_fast_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NS = 8;
    localparam logic [31:0] SPU = 32'h5A5A_0001;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [NS-1:0] src = '0;
    logic [NS-1:0][1:0] styp = 16'h0080;
    logic [NS-1:0][2:0] sprio = 24'h000800;
    logic [7:0] stb = '0;
    logic [NS-1:0] cmd = '0;
    logic [31:0] sdat = '0;
    logic protect_on = 1'b0;
    logic mask_all = 1'b0;
    logic autor = 1'b0;
    logic fvr_rd, fiq_n, irq_n, wake;
    logic [31:0] rdat;
    logic [2:0] cur;
    logic [NS-1:0] pend, forc;
    logic [6:0] mode;
    int n_reads;
    int fail_count = 0;
    int checks_done = 0;
    // free-running system clock
    always #50 clk = ~clk;
    vic_fast_ctrl #(.NSRC(NS), .DEPTH(4)) uut (
        .i_mclk(clk), .i_rst(rst), .i_src(src), .i_src_external(8'h00), .i_src_type(styp),
        .i_src_prio(sprio), .i_src_enable(8'h09), .i_smr0_wr(stb[0]), .i_smr0_data(sdat[6:0]),
        .i_svr_wr(stb[1]), .i_svr_idx(cmd[2:0]), .i_svr_data(sdat), .i_spurious_vector(SPU),
        .i_protect_mode_bit(protect_on), .i_global_mask_bit(mask_all), .i_fvr_rd(fvr_rd), .i_ivr_rd(stb[2]),
        .i_ivr_wr(stb[3]), .i_eoi_wr(stb[4]), .i_ffer_wr(stb[5]), .i_ffdr_wr(stb[6]),
        .i_clear_cmd_wr(stb[7]), .i_cmd_data(cmd), .o_fast_request_line_n(fiq_n),
        .o_normal_request_line_n(irq_n), .o_wake(wake), .o_rd_data(rdat), .o_current_source_status(cur),
        .o_pending_status(pend), .o_forcing_status(forc), .o_source_zero_mode(mode));
    vic_core_model core (.i_mclk(clk), .i_rst(rst), .i_auto(autor), .i_fast_request_line_n(fiq_n),
        .o_fvr_rd(fvr_rd), .o_reads(n_reads));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle strobe on bit b with mask or index d and data v
    task automatic pulse(input int b, input logic [NS-1:0] d, input logic [31:0] v);
        @(posedge clk);
        stb[b] <= 1'b1;
        cmd <= d;
        sdat <= v;
        @(posedge clk);
        stb[b] <= 1'b0;
        tick(2);
    endtask
    // pin change, then wait out two sync stages and the output register
    task automatic setsrc(input int i, input logic v);
        @(posedge clk);
        src[i] <= v;
        tick(5);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    // main test sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk("fiq_n", 1, fiq_n);
        chk("irq_n", 1, irq_n);
        chk("forcing", 0, forc);
        pulse(0, 0, 32'h25);
        pulse(1, 0, 32'hA0A0_0000);
        pulse(1, 3, 32'hB0B0_0003);
        chk("mode", 7'h25, mode);
        $display("test reset and config done");
        setsrc(0, 1);
        setsrc(0, 0);
        chk("fiq_n", 0, fiq_n);
        @(posedge clk) autor <= 1'b1;
        tick(8);
        chk("fiq_n", 1, fiq_n);
        chk("rd_data", 32'hA0A0_0000, rdat);
        chk("reads", 1, n_reads);
        pulse(0, 0, 32'h40);
        setsrc(0, 1);
        tick(8);
        chk("fiq_n", 0, fiq_n);
        @(posedge clk) autor <= 1'b0;
        setsrc(0, 0);
        chk("fiq_n", 1, fiq_n);
        pulse(0, 0, 32'h25);
        $display("test fast source done");
        pulse(5, 8'h08, 0);
        chk("forcing", 8'h08, forc);
        setsrc(3, 1);
        chk("fiq_n", 0, fiq_n);
        chk("irq_n", 1, irq_n);
        chk("pend0", 0, pend[0]);
        setsrc(0, 1);
        setsrc(0, 0);
        @(posedge clk) autor <= 1'b1;
        tick(8);
        @(posedge clk) autor <= 1'b0;
        tick(6);
        chk("pend0", 1, pend[0]);
        chk("rd_data", 32'hA0A0_0000, rdat);
        pulse(7, 8'h01, 0);
        chk("pend0", 0, pend[0]);
        pulse(2, 0, 0);
        chk("rd_data", SPU, rdat);
        chk("pend3", 1, pend[3]);
        pulse(6, 8'h08, 0);
        chk("forcing", 0, forc);
        tick(3);
        chk("irq_n", 0, irq_n);
        $display("test forcing done");
        pulse(2, 0, 0);
        chk("rd_data", 32'hB0B0_0003, rdat);
        chk("current", 3, cur);
        pulse(3, 0, 0);
        chk("current", 3, cur);
        pulse(4, 0, 0);
        chk("current", 0, cur);
        @(posedge clk) protect_on <= 1'b1;
        pulse(2, 0, 0);
        pulse(2, 0, 0);
        chk("rd_data", 32'hB0B0_0003, rdat);
        chk("current", 0, cur);
        pulse(3, 0, 0);
        chk("current", 3, cur);
        pulse(4, 0, 0);
        chk("current", 0, cur);
        @(posedge clk) protect_on <= 1'b0;
        $display("test protect mode done");
        @(posedge clk) mask_all <= 1'b1;
        setsrc(0, 1);
        chk("irq_n", 1, irq_n);
        chk("fiq_n", 1, fiq_n);
        chk("wake", 1, wake);
        @(posedge clk) mask_all <= 1'b0;
        tick(3);
        chk("fiq_n", 0, fiq_n);
        $display("test general mask done");
        end_sim();
    end
endmodule // vic_fast_ctrl_tb_top
`default_nettype wire
